// [phw_port.sv]
// pcm highway time-slot port for three serial channels, apb register access
`default_nettype none
module phw_port (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        highway_shared_clock,
    input  wire logic        highway_rx_line,
    input  wire logic        slot_select_low,
    input  wire logic        slot_select_high,
    output logic             highway_tx_line,
    output logic      [2:0]  request_to_send
);
    phw_pkg::phw_state_t r_reg;
    phw_pkg::phw_state_t r_next;

    logic       rise;
    logic [1:0] slot;
    logic       sync;
    logic [1:0] owner;
    logic       wr;
    logic       rd;
    logic [1:0] idx;
    logic       in_txd;
    logic       in_rxd;
    logic       mapped;

    // ========================================================
    // apb decode
    assign wr     = psel & penable & pwrite;
    assign rd     = psel & penable & ~pwrite;
    assign idx    = paddr[3:2];
    assign in_txd = (paddr[7:4] == phw_pkg::TXD_OFS[7:4]) && (paddr[1:0] == 2'h0)
                    && (idx != 2'h3);
    assign in_rxd = (paddr[7:4] == phw_pkg::RXD_OFS[7:4]) && (paddr[1:0] == 2'h0)
                    && (idx != 2'h3);
    assign mapped = (paddr == phw_pkg::CTRL_OFS) || (paddr == phw_pkg::ROUTE_OFS)
                    || (paddr == phw_pkg::STATUS_OFS) || in_txd || in_rxd;
    // zero wait states keep the line timing independent of bus traffic
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always_comb begin
        prdata = 32'h0;
        if (paddr == phw_pkg::CTRL_OFS) begin
            prdata[phw_pkg::CTRL_TXEN_POS +: 3] = r_reg.tx_en;
            prdata[phw_pkg::CTRL_RXEN_POS +: 3] = r_reg.rx_en;
            prdata[phw_pkg::CTRL_ENV_POS]       = r_reg.envelope;
            prdata[phw_pkg::CTRL_PSEL_POS +: 3] = r_reg.pio_sel;
            prdata[phw_pkg::CTRL_PVAL_POS +: 3] = r_reg.pio_val;
        end else if (paddr == phw_pkg::ROUTE_OFS) begin
            prdata[5:0] = r_reg.route;
        end else if (paddr == phw_pkg::STATUS_OFS) begin
            for (int i = 0; i < 3; i++) begin
                prdata[i*phw_pkg::ST_STRIDE + phw_pkg::ST_HOLD_POS] = r_reg.ch[i].hold_vld;
                prdata[i*phw_pkg::ST_STRIDE + phw_pkg::ST_RTS_POS]  = r_reg.ch[i].rts;
                prdata[i*phw_pkg::ST_STRIDE + phw_pkg::ST_RXV_POS]  = r_reg.ch[i].rx_vld;
                prdata[i*phw_pkg::ST_STRIDE + phw_pkg::ST_CD_POS]   = ~r_reg.rx_en[i];
                prdata[i*phw_pkg::ST_STRIDE + phw_pkg::ST_CTS_POS]  = ~r_reg.tx_en[i];
            end
        end else if (in_txd) begin
            prdata[0] = r_reg.ch[idx].hold_vld;
        end else if (in_rxd) begin
            prdata[15:0] = r_reg.ch[idx].rx_data;
        end
    end

    // ========================================================
    // slot timing
    assign rise = r_reg.lclk[1] & ~r_reg.lclk[2];
    // envelope: code marks the slot itself; otherwise a counted 8-bit slot
    assign slot = r_reg.envelope ? r_reg.code
                : ((r_reg.ocp_cnt != 4'h0) ? r_reg.ocp_code : 2'h0);
    assign sync = rise && (slot != 2'h0) && (slot != r_reg.prev_code);

    always_comb begin
        case (slot)
            2'h1:    owner = r_reg.route[1:0];
            2'h2:    owner = r_reg.route[3:2];
            2'h3:    owner = r_reg.route[5:4];
            default: owner = 2'h3;
        endcase
    end

    // ========================================================
    // next state
    always_comb begin
        r_next        = r_reg;
        r_next.lclk   = {r_reg.lclk[1:0], highway_shared_clock};
        r_next.code_m = {slot_select_high, slot_select_low};
        r_next.code   = r_reg.code_m;
        r_next.rxd_m  = highway_rx_line;
        r_next.rxd    = r_reg.rxd_m;

        if (rise) begin
            r_next.prev_code = slot;
            r_next.txd       = 1'b1;
            if (!r_reg.envelope) begin
                if (r_reg.ocp_cnt != 4'h0) begin
                    r_next.ocp_cnt = r_reg.ocp_cnt - 4'h1;
                end
                // a code seen now opens a slot at the next clock
                if (r_reg.code != 2'h0) begin
                    r_next.ocp_code = r_reg.code;
                    r_next.ocp_cnt  = phw_pkg::SLOT_BITS;
                end
            end
        end

        if (wr) begin
            if (paddr == phw_pkg::CTRL_OFS) begin
                r_next.tx_en    = pwdata[phw_pkg::CTRL_TXEN_POS +: 3];
                r_next.rx_en    = pwdata[phw_pkg::CTRL_RXEN_POS +: 3];
                r_next.envelope = pwdata[phw_pkg::CTRL_ENV_POS];
                r_next.pio_sel  = pwdata[phw_pkg::CTRL_PSEL_POS +: 3];
                r_next.pio_val  = pwdata[phw_pkg::CTRL_PVAL_POS +: 3];
            end else if (paddr == phw_pkg::ROUTE_OFS) begin
                r_next.route = pwdata[5:0];
            end else if (in_txd && !r_reg.ch[idx].hold_vld) begin
                // a full holding byte refuses the write silently
                r_next.ch[idx].hold      = pwdata[7:0];
                r_next.ch[idx].hold_last = pwdata[phw_pkg::TXD_LAST_POS];
                r_next.ch[idx].hold_vld  = 1'b1;
            end
        end
        if (rd && in_rxd) begin
            r_next.ch[idx].rx_vld = 1'b0;
        end

        for (int i = 0; i < 3; i++) begin
            // ----- transmit
            if (!r_reg.tx_en[i]) begin
                r_next.ch[i].tx_st = phw_pkg::TX_IDLE;
                r_next.ch[i].rts   = 1'b0;
            end else begin
                case (r_reg.ch[i].tx_st)
                    phw_pkg::TX_IDLE: begin
                        if (r_reg.ch[i].hold_vld) begin
                            r_next.ch[i].tx_st = phw_pkg::TX_WAIT;
                            r_next.ch[i].cnt   = 6'h0;
                        end
                    end
                    phw_pkg::TX_WAIT: begin
                        if (rise) begin
                            if (r_reg.ch[i].cnt == phw_pkg::TX_START_CLKS - 6'h1) begin
                                r_next.ch[i].rts   = 1'b1;
                                r_next.ch[i].tx_st = phw_pkg::TX_ARMED;
                            end else begin
                                r_next.ch[i].cnt = r_reg.ch[i].cnt + 6'h1;
                            end
                        end
                    end
                    phw_pkg::TX_ARMED: begin
                        // no clear-to-send gate: the slot edge alone starts it
                        if (sync && owner == 2'(i)) begin
                            r_next.ch[i].tx_st    = phw_pkg::TX_SEND;
                            r_next.txd            = phw_pkg::IDLE_BYTE[7];
                            r_next.ch[i].sh       = {phw_pkg::IDLE_BYTE[6:0], 1'b1};
                            r_next.ch[i].bits     = 3'h7;
                            r_next.ch[i].cur_last = 1'b0;
                        end
                    end
                    default: begin
                        if (rise && slot != 2'h0 && owner == 2'(i)) begin
                            if (r_reg.ch[i].bits != 3'h0) begin
                                r_next.txd         = r_reg.ch[i].sh[7];
                                r_next.ch[i].sh    = {r_reg.ch[i].sh[6:0], 1'b1};
                                r_next.ch[i].bits  = r_reg.ch[i].bits - 3'h1;
                            end else if (r_reg.ch[i].hold_vld) begin
                                r_next.txd            = r_reg.ch[i].hold[7];
                                r_next.ch[i].sh       = {r_reg.ch[i].hold[6:0], 1'b1};
                                r_next.ch[i].bits     = 3'h7;
                                r_next.ch[i].cur_last = r_reg.ch[i].hold_last;
                                r_next.ch[i].hold_vld = 1'b0;
                            end else if (r_reg.ch[i].cur_last) begin
                                r_next.ch[i].tx_st = phw_pkg::TX_IDLE;
                                r_next.ch[i].rts   = 1'b0;
                            end else begin
                                // underrun inside a frame pads with ones
                                r_next.ch[i].sh   = {phw_pkg::IDLE_BYTE[6:0], 1'b1};
                                r_next.ch[i].bits = 3'h7;
                            end
                        end
                    end
                endcase
            end

            // ----- receive
            if (!r_reg.rx_en[i]) begin
                r_next.ch[i].rx_armed = 1'b0;
                r_next.ch[i].rx_bits  = 5'h0;
                r_next.ch[i].rx_pend  = 1'b0;
            end else if (rise && slot != 2'h0 && owner == 2'(i)) begin
                if (r_reg.ch[i].rx_pend) begin
                    if (r_reg.ch[i].rx_wait == phw_pkg::RX_WB_CLKS - 4'h1) begin
                        r_next.ch[i].rx_data = r_reg.ch[i].rx_word;
                        r_next.ch[i].rx_vld  = 1'b1;
                        r_next.ch[i].rx_pend = 1'b0;
                    end else begin
                        r_next.ch[i].rx_wait = r_reg.ch[i].rx_wait + 4'h1;
                    end
                end
                if (r_reg.ch[i].rx_armed || sync) begin
                    r_next.ch[i].rx_armed = 1'b1;
                    r_next.ch[i].rx_sh    = {r_reg.ch[i].rx_sh[14:0], r_reg.rxd};
                    if (r_reg.ch[i].rx_bits == phw_pkg::RX_WORD_BITS - 5'h1) begin
                        r_next.ch[i].rx_word = {r_reg.ch[i].rx_sh[14:0], r_reg.rxd};
                        r_next.ch[i].rx_pend = 1'b1;
                        r_next.ch[i].rx_wait = 4'h0;
                        r_next.ch[i].rx_bits = 5'h0;
                    end else begin
                        r_next.ch[i].rx_bits = r_reg.ch[i].rx_bits + 5'h1;
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg       <= '0;
            r_reg.route <= phw_pkg::ROUTE_RST;
            r_reg.txd   <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // ========================================================
    // pins
    assign highway_tx_line = r_reg.txd;
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            request_to_send[i] = r_reg.pio_sel[i] ? r_reg.pio_val[i]
                                                  : r_reg.ch[i].rts;
        end
    end
endmodule
`default_nettype wire

// [phw_pkg.sv]
// constants, register map and state types for the pcm highway port
`default_nettype none
package phw_pkg;
    // ========================================================
    // register map (byte addresses)
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] ROUTE_OFS  = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] TXD_OFS    = 8'h10;
    localparam logic [7:0] RXD_OFS    = 8'h20;

    // ========================================================
    // field positions
    localparam int CTRL_TXEN_POS = 0;
    localparam int CTRL_RXEN_POS = 4;
    localparam int CTRL_ENV_POS  = 8;
    localparam int CTRL_PSEL_POS = 12;
    localparam int CTRL_PVAL_POS = 16;
    localparam int TXD_LAST_POS  = 8;
    localparam int ST_STRIDE     = 8;
    localparam int ST_HOLD_POS   = 0;
    localparam int ST_RTS_POS    = 1;
    localparam int ST_RXV_POS    = 2;
    localparam int ST_CD_POS     = 3;
    localparam int ST_CTS_POS    = 4;

    // ========================================================
    // reset values and timing counts (in line clocks)
    localparam logic [5:0]  ROUTE_RST     = 6'h24;
    localparam logic [3:0]  SLOT_BITS     = 4'h8;
    localparam logic [5:0]  TX_START_CLKS = 6'h10;
    localparam logic [3:0]  RX_WB_CLKS    = 4'h9;
    localparam logic [4:0]  RX_WORD_BITS  = 5'h10;
    localparam logic [7:0]  IDLE_BYTE     = 8'hff;

    // ========================================================
    // state types
    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_ARMED, TX_SEND} phw_tx_st_t;

    typedef struct packed {
        phw_tx_st_t  tx_st;
        logic [5:0]  cnt;
        logic [7:0]  sh;
        logic [2:0]  bits;
        logic        cur_last;
        logic        rts;
        logic [7:0]  hold;
        logic        hold_vld;
        logic        hold_last;
        logic [15:0] rx_sh;
        logic [4:0]  rx_bits;
        logic        rx_pend;
        logic [15:0] rx_word;
        logic [3:0]  rx_wait;
        logic [15:0] rx_data;
        logic        rx_vld;
        logic        rx_armed;
    } phw_chan_t;

    typedef struct packed {
        logic [2:0]      lclk;
        logic [1:0]      code_m;
        logic [1:0]      code;
        logic            rxd_m;
        logic            rxd;
        logic [1:0]      ocp_code;
        logic [3:0]      ocp_cnt;
        logic [1:0]      prev_code;
        logic            txd;
        logic [2:0]      tx_en;
        logic [2:0]      rx_en;
        logic            envelope;
        logic [2:0]      pio_sel;
        logic [2:0]      pio_val;
        logic [5:0]      route;
        phw_chan_t [2:0] ch;
    } phw_state_t;
endpackage
`default_nettype wire

// [phw_port_props.sv]
// assertion checker for the pcm highway port
`default_nettype none
module phw_port_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        highway_shared_clock,
    input wire logic        highway_rx_line,
    input wire logic        slot_select_low,
    input wire logic        slot_select_high,
    input wire logic        highway_tx_line,
    input wire logic [2:0]  request_to_send
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================================
    // register shadow and line clock history
    logic [18:0] ctrl_q;
    logic [5:0]  route_q;
    logic [7:0]  lck_h;
    logic        acc, rd, rise;
    assign acc = psel && penable;
    assign rd = acc && !pwrite;
    // a rise within 7 samples covers the pin synchroniser delay
    assign rise = |(lck_h[6:0] & ~lck_h[7:1]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= '0;
            route_q <= phw_pkg::ROUTE_RST;
            lck_h <= '0;
        end else begin
            lck_h <= {lck_h[6:0], highway_shared_clock};
            if (acc && pwrite && paddr == phw_pkg::CTRL_OFS)
                ctrl_q <= pwdata[18:0];
            if (acc && pwrite && paddr == phw_pkg::ROUTE_OFS)
                route_q <= pwdata[5:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ========================================================
    // assertions
    chk_zero_wait: assert property (acc |-> pready) else $error("access not ready");
    chk_unmapped_err: assert property (acc |-> pslverr == !(paddr inside {8'h00,
        8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28})) else $error("bad pslverr");
    chk_route_read: assert property (rd && paddr == phw_pkg::ROUTE_OFS |->
        prdata == {26'h0, route_q}) else $error("route readback wrong");
    chk_status_bits: assert property (rd && paddr == phw_pkg::STATUS_OFS |->
        {prdata[19], prdata[11], prdata[3]} == ~ctrl_q[6:4]
        && {prdata[20], prdata[12], prdata[4]} == ~ctrl_q[2:0]) else $error("cd cts wrong");
    chk_pio_level: assert property ($stable(ctrl_q) |->
        ((request_to_send ^ ctrl_q[18:16]) & ctrl_q[14:12]) == 3'h0) else $error("pio wrong");
    chk_rts_needs_en: assert property ((request_to_send & ~$past(request_to_send)
        & ~ctrl_q[14:12] & ~ctrl_q[2:0]) == 3'h0) else $error("rts rose while disabled");
    chk_rts_on_clk: assert property ($stable(ctrl_q) && ((request_to_send ^
        $past(request_to_send)) & ~ctrl_q[14:12]) != 3'h0 |-> rise)
        else $error("rts moved without line clock");
    chk_tx_on_clk: assert property ($changed(highway_tx_line) |-> rise)
        else $error("tx moved without line clock");
    cover property ($rose(request_to_send[0]));
    cover property (rd && paddr == phw_pkg::STATUS_OFS);
    cover property (acc && pslverr);
endmodule
bind phw_port phw_port_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .highway_shared_clock(highway_shared_clock),
    .highway_rx_line(highway_rx_line), .slot_select_low(slot_select_low),
    .slot_select_high(slot_select_high), .highway_tx_line(highway_tx_line),
    .request_to_send(request_to_send));
`default_nettype wire

// [phw_hwy_model.sv]
// far-side highway model: line clock, slot codes, rx data, tx capture
`default_nettype none
module phw_hwy_model (
    input  wire logic env,
    input  wire logic txd,
    output logic      lclk,
    output logic      sy_lo,
    output logic      sy_hi,
    output logic      rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] tx_byte = 8'h00;
    int         rises = 0;
    event       done;
    initial begin
        lclk = 1'b0;  // input only, made here and still between slots
        {sy_hi, sy_lo} = 2'b00;
        rxd = 1'b1;
    end
    task automatic tick();
        #40 lclk = 1'b1;
        rises++;
        #40 lclk = 1'b0;
    endtask
    // a code-free rise closes each slot so the next one starts with a sync edge
    task automatic slot(input logic [1:0] c, input int n, input logic [7:0] rx);
        #3;
        if (!env) begin
            {sy_hi, sy_lo} = c;
            tick();
            {sy_hi, sy_lo} = 2'b00;
        end
        for (int i = 0; i < n; i++) begin
            if (env) {sy_hi, sy_lo} = c;
            rxd = rx[7 - i];
            tick();
            tx_byte = {tx_byte[6:0], txd};
        end
        {sy_hi, sy_lo} = 2'b00;
        rxd = ~rxd;
        tick();
        -> done;
    endtask
endmodule
`default_nettype wire

// [tb.sv]
// bench: apb driver, highway traffic, queued tx byte checks
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, s_dat, rv;
    logic        pready, pslverr, lclk, sy_lo, sy_hi, rxd, txd, env = 1'b0;
    logic        s_rdy, s_err, ev, s_tick = 1'b0;
    logic [2:0]  rts;
    logic [7:0]  exp_q[$];
    int          mismatches = 0, samples_checked = 0, seed = 97;
    always #4 pclk = ~pclk;
    phw_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .highway_shared_clock(lclk), .highway_rx_line(rxd),
        .slot_select_low(sy_lo), .slot_select_high(sy_hi), .highway_tx_line(txd),
        .request_to_send(rts));
    phw_hwy_model hwy_u (.env(env), .txd(txd), .lclk(lclk), .sy_lo(sy_lo),
        .sy_hi(sy_hi), .rxd(rxd));
    // ========================================================
    // answer as it stood at the edge, then wake the driver
    always @(posedge pclk) begin
        s_rdy <= psel && penable && pready;
        s_err <= pslverr;
        s_dat <= prdata;
        s_tick <= ~s_tick;
    end
    always @(hwy_u.done) begin
        if (exp_q.size() > 0)
            chk("tx byte", hwy_u.tx_byte, exp_q.pop_front());
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(s_tick);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(s_tick);
        penable <= 1'b1;
        @(s_tick);
        while (s_rdy !== 1'b1) @(s_tick);
        rv = s_dat;
        ev = s_err;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wtx(input int ch, input logic [8:0] v);
        apb(1'b1, phw_pkg::TXD_OFS + 8'(4 * ch), {23'h0, v});
    endtask
    task automatic tslot(input logic [1:0] c, input logic [7:0] e);
        exp_q.push_back(e);
        hwy_u.slot(c, 8, 8'($random(seed)));
    endtask
    initial begin
        logic [1:0]  c;
        logic [5:0]  rt;
        logic [7:0]  d1, d2;
        logic [15:0] w;
        int          ch, n;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, phw_pkg::ROUTE_OFS, 32'h0);
        chk("route reset", rv, 32'h24);
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", ev, 1'b1);
        d1 = 8'($random(seed));
        apb(1'b1, phw_pkg::CTRL_OFS, {13'h0, d1[2:0], 16'h7070});
        apb(1'b0, phw_pkg::STATUS_OFS, 32'h0);
        chk("pio rts", rts, d1[2:0]);
        chk("cd cts", rv & 32'h181818, 32'h101010);
        for (int k = 1; k <= 3; k++) begin
            c = 2'(k);
            ch = k % 3;
            rt = (6'h3f & ~(6'h3 << (2 * k - 2))) | (6'(ch) << (2 * k - 2));
            apb(1'b1, phw_pkg::ROUTE_OFS, {26'h0, rt});
            apb(1'b0, phw_pkg::ROUTE_OFS, 32'h0);
            chk("route", rv, {26'h0, rt});
            env = 1'b1;
            d1 = 8'($random(seed));
            d2 = 8'($random(seed));
            wtx(ch, {1'b0, d1});
            // enabled between slots so the start delay is repeatable
            // no enable inside a slot: fewer than 36 clocks would follow it
            // host picks transparent envelope framing, no sync pattern
            apb(1'b1, phw_pkg::CTRL_OFS, 32'h100 | (32'h1 << ch));
            n = hwy_u.rises;
            while (rts[ch] !== 1'b1 && hwy_u.rises - n < 40) tslot(c, 8'hff);
            chk("rts delay", 32'(hwy_u.rises - n < 36), 1);
            tslot(c, 8'hff);
            apb(1'b0, phw_pkg::STATUS_OFS, 32'h0);
            n = int'(rv[8 * ch]);
            if (n == 0) wtx(ch, {1'b1, d2});
            tslot(c, d1);
            chk("rts held", rts[ch], 1'b1);
            if (n != 0) wtx(ch, {1'b1, d2});
            tslot(c, d2);
            tslot(c, 8'hff);
            chk("rts drop", rts[ch], 1'b0);
            env = 1'b0;
            w = 16'($random(seed));
            apb(1'b1, phw_pkg::CTRL_OFS, 32'h10 << ch);
            hwy_u.slot(c, 8, w[15:8]);
            hwy_u.slot(2'(k % 3 + 1), 8, ~w[7:0]);
            hwy_u.slot(c, 8, w[7:0]);
            hwy_u.slot(c, 8, 8'h00);
            apb(1'b0, phw_pkg::STATUS_OFS, 32'h0);
            chk("rx early", rv[8 * ch + 2], 1'b0);
            hwy_u.slot(c, 8, 8'h00);
            apb(1'b0, phw_pkg::STATUS_OFS, 32'h0);
            chk("rx valid", rv[8 * ch + 2], 1'b1);
            apb(1'b0, phw_pkg::RXD_OFS + 8'(4 * ch), 32'h0);
            chk("rx word", rv[15:0], w);
        end
        give_verdict();
    end
    initial begin
        #300000;
        mismatches++;
        give_verdict();
    end
endmodule
`default_nettype wire
